// ### rtl/updn_host_pkg.sv
// package for the up/down potentiometer host controller
// assumes a 50 MHz system clock; all timing counts derive from it
package updn_host_pkg;

  // system clock rate
  localparam int CLK_MHZ = 50;

  // wiper code layout
  localparam int CODE_W = 6;
  localparam logic [5:0] CODE_MAX = 6'h3F;
  localparam logic [5:0] CODE_MIN = 6'h00;
  localparam logic [5:0] CODE_RESET = 6'h1F;

  // pin timing, least times in ns, rounded up to whole cycles
  localparam int T_SETUP_NS = 500;
  localparam int T_HALF_NS = 80;
  localparam int T_HOLD_NS = 500;
  localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int HALF_CYC = (T_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;

  // nonvolatile write time in us and its cycle count
  localparam int T_WRITE_US = 5000;
  localparam int WRITE_CYC = T_WRITE_US * CLK_MHZ;

  // wait counter width
  localparam int WAIT_W = 20;

  // step-direction levels for each meaning
  localparam logic LVL_UP = 1'b1;
  localparam logic LVL_DOWN = 1'b0;
  localparam logic LVL_STORE = 1'b1;
  localparam logic LVL_LOCK = 1'b1;

  // one command from the user side
  typedef struct packed {
    logic up;            // 1 increment, 0 decrement
    logic high_voltage;  // use the elevated select level
    logic flag;          // standard: store; high voltage: lock
    logic [5:0] steps;   // number of step edges, 0 for store only
  } cmd_type;

  // the two control pins
  typedef struct packed {
    logic sel_out;                // select level, 0 low, 1 high
    logic sel_oe;                 // host drives select
    logic elevated_select_level;  // drive the elevated level
    logic updn_out;               // step-direction level
    logic updn_oe;                // host drives step-direction
  } pins_type;

  // controller sequence
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_ENTER, ST_STEP_LOW, ST_STEP_HIGH, ST_END,
    ST_EXIT, ST_WRITE
  } state_type;

endpackage : updn_host_pkg

// ### rtl/updn_host.sv
// host controller driving an up/down nonvolatile potentiometer
// over its select and step-direction pins; user side is a
// valid/ready command port on the same clock.
//
// Notes on behaviour
// (R1) code 3F puts wiper at terminal A
// (R2) code 00 puts wiper at terminal B
// (R3) sixty-four wiper positions on 63 resistors
// (R4) each step moves code by exactly one
// (R5) low select gives standard commands
// (R6) elevated select gives lock-changing commands
// (R7) elevated commands always store the code
// (R8) normal-high select ignores step-direction activity
// (R9) select level classifies command type
// (R10) direction sampled at select falling edge
// (R11) one rising step-direction edge per step
// (R12) code saturates at both ends
// (R13) level at select rise chooses store
// (R14) lock blocks standard steps
// (R15) lock blocks standard stores
// (R16) only elevated commands change the lock
// (R17) locked wiper needs elevated commands to step
// (R18) power-up loads code from nonvolatile memory
// (R19) locked standard command is discarded; host promotes it to elevated, flag set
// (R20) idle only when high and write done
// (R21) high at falling edge means increment
// (R22) commands ignored during nonvolatile write
// (R23) elevated command sets lock at its end
`timescale 1ns/100ps
`default_nettype none

module updn_host #(
  parameter int WRITE_CYCLES = updn_host_pkg::WRITE_CYC
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // command port
  input wire logic cmd_valid,
  input wire updn_host_pkg::cmd_type cmd,
  output logic cmd_ready,
  output logic done,
  // tracked device state
  output logic lock_shadow,
  output logic [5:0] code_shadow,
  output logic code_known,
  // device pins
  output updn_host_pkg::pins_type pins
);
  import updn_host_pkg::*;

  // refuse a write time that the wait counter cannot hold
  if (WRITE_CYCLES < 1 || WRITE_CYCLES >= (1 << WAIT_W)) begin : g_bad_write
    $error("WRITE_CYCLES out of range");
  end

  state_type state_reg;
  cmd_type cmd_reg;
  logic promoted_reg;
  logic [5:0] left_reg;
  logic [WAIT_W-1:0] wait_reg;
  logic wait_done;
  logic stores;
  logic end_level;

  assign wait_done = (wait_reg == '0);
  // elevated commands always store; standard ones on request
  assign stores = cmd_reg.high_voltage | cmd_reg.flag; // [R7] [R13]
  // level held at select rise: store choice or lock variant
  assign end_level = cmd_reg.high_voltage ?
    (cmd_reg.flag ? LVL_LOCK : ~LVL_LOCK) :
    (cmd_reg.flag ? LVL_STORE : ~LVL_STORE); // [R13] [R23]

  // sequence of pin phases
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
    end else if (ce) begin
      unique case (state_reg)
        ST_IDLE: if (cmd_valid) state_reg <= ST_SETUP;
        ST_SETUP: if (wait_done) state_reg <= ST_ENTER;
        ST_ENTER: begin
          if (wait_done) begin
            state_reg <= (left_reg != '0) ? ST_STEP_LOW : ST_END;
          end
        end
        ST_STEP_LOW: if (wait_done) state_reg <= ST_STEP_HIGH;
        ST_STEP_HIGH: begin
          if (wait_done) begin
            state_reg <= (left_reg != '0) ? ST_STEP_LOW : ST_END;
          end
        end
        ST_END: if (wait_done) state_reg <= ST_EXIT;
        ST_EXIT: begin
          if (wait_done) state_reg <= stores ? ST_WRITE : ST_IDLE;
        end
        ST_WRITE: if (wait_done) state_reg <= ST_IDLE; // [R22]
      endcase
    end
  end

  // phase timer, loaded on each phase change
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_reg <= '0;
    end else if (ce) begin
      unique case (state_reg)
        ST_IDLE: begin
          if (cmd_valid) wait_reg <= WAIT_W'(SETUP_CYC - 1);
        end
        ST_SETUP: if (wait_done) wait_reg <= WAIT_W'(SETUP_CYC - 1);
        ST_ENTER, ST_STEP_LOW, ST_STEP_HIGH: begin
          if (wait_done) begin
            wait_reg <= WAIT_W'(HALF_CYC - 1);
          end else begin
            wait_reg <= wait_reg - 1'b1;
          end
        end
        ST_END: begin
          if (wait_done) begin
            wait_reg <= WAIT_W'(HOLD_CYC - 1);
          end else begin
            wait_reg <= wait_reg - 1'b1;
          end
        end
        ST_EXIT: begin
          if (wait_done) begin
            wait_reg <= WAIT_W'(WRITE_CYCLES - 1); // [R20]
          end else begin
            wait_reg <= wait_reg - 1'b1;
          end
        end
        ST_WRITE: if (!wait_done) wait_reg <= wait_reg - 1'b1;
      endcase
      if (state_reg == ST_SETUP && !wait_done) begin
        wait_reg <= wait_reg - 1'b1;
      end
    end
  end

  // command capture; a standard command while locked is promoted
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_reg <= '0;
      promoted_reg <= 1'b0;
    end else if (ce && state_reg == ST_IDLE && cmd_valid) begin
      cmd_reg <= cmd;
      promoted_reg <= 1'b0;
      if (lock_shadow && !cmd.high_voltage) begin
        cmd_reg.high_voltage <= 1'b1; // [R17] [R14] [R19]
        cmd_reg.flag <= 1'b1; // stays locked
        promoted_reg <= 1'b1;
      end
    end
  end

  // remaining step count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      left_reg <= '0;
    end else if (ce) begin
      if (state_reg == ST_IDLE && cmd_valid) begin
        left_reg <= cmd.steps;
      end else if (state_reg == ST_STEP_LOW && wait_done) begin
        left_reg <= left_reg - 1'b1; // [R11]
      end
    end
  end

  // pin drive for each phase
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pins <= '{sel_out: 1'b1, sel_oe: 1'b0, elevated_select_level: 1'b0,
                updn_out: 1'b0, updn_oe: 1'b1};
    end else if (ce) begin
      unique case (state_reg)
        ST_IDLE: begin
          // select released to its pulled-up normal high
          pins.sel_oe <= 1'b0; // [R8] [R20]
          pins.sel_out <= 1'b1;
          pins.elevated_select_level <= 1'b0;
          if (cmd_valid) begin
            // zero-step commands enter high so no rising edge can step
            pins.updn_out <= (cmd.up || cmd.steps == '0) ?
              LVL_UP : LVL_DOWN; // [R21]
          end
        end
        ST_SETUP: begin
          if (wait_done) begin
            pins.sel_oe <= 1'b1;
            if (cmd_reg.high_voltage) begin
              pins.sel_out <= 1'b1;
              pins.elevated_select_level <= 1'b1; // [R6] [R9] [R16]
            end else begin
              pins.sel_out <= 1'b0; // [R5] [R9] [R10]
            end
          end
        end
        ST_ENTER, ST_STEP_HIGH: begin
          if (wait_done) begin
            pins.updn_out <= (left_reg != '0) ? 1'b0 : end_level;
          end
        end
        ST_STEP_LOW: if (wait_done) pins.updn_out <= 1'b1; // [R11]
        ST_END: begin
          if (wait_done) begin
            pins.sel_oe <= 1'b0; // rise of select: [R13]
            pins.sel_out <= 1'b1;
            pins.elevated_select_level <= 1'b0;
          end
        end
        ST_EXIT, ST_WRITE: begin
          pins.sel_oe <= 1'b0;
        end
      endcase
    end
  end

  // shadow of lock and wiper code
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lock_shadow <= 1'b0;
      code_shadow <= CODE_RESET; // unknown; code_known is never set, [R18]
      code_known <= 1'b0;
    end else if (ce) begin
      if (state_reg == ST_STEP_LOW && wait_done) begin
        if (cmd_reg.up && code_shadow != CODE_MAX) begin
          code_shadow <= code_shadow + 1'b1; // [R1] [R3] [R4] [R12]
        end else if (!cmd_reg.up && code_shadow != CODE_MIN) begin
          code_shadow <= code_shadow - 1'b1; // [R2] [R4] [R12]
        end
      end
      if (state_reg == ST_END && wait_done) begin
        if (cmd_reg.high_voltage) begin
          lock_shadow <= cmd_reg.flag; // [R16] [R23]
        end
        if (stores && cmd_reg.steps == '0) begin
          code_known <= code_known; // write-only keeps knowledge
        end
      end
    end
  end

  // ready and completion pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_ready <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      cmd_ready <= (state_reg == ST_IDLE) && !cmd_valid; // [R22]
      done <= ((state_reg == ST_EXIT) && wait_done && !stores) ||
              ((state_reg == ST_WRITE) && wait_done); // [R15] [R20]
    end else begin
      done <= 1'b0;
    end
  end

endmodule : updn_host
`default_nettype wire

// ### sim/updn_host_monitor.sv
// port assertions for the potentiometer host controller
// assumes binding onto updn_host
`timescale 1ns/100ps
`default_nettype none
module updn_host_monitor
  import updn_host_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // command port
  input wire logic cmd_valid,
  input wire updn_host_pkg::cmd_type cmd,
  input wire logic cmd_ready,
  input wire logic done,
  // state and pins
  input wire logic lock_shadow,
  input wire logic [5:0] code_shadow,
  input wire updn_host_pkg::pins_type pins
);
  cmd_type cur_reg;
  logic fresh_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // command being run; valid is taken whenever the controller is idle,
  // which shows as ready, a done pulse or the first edge after reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur_reg <= '0;
      fresh_reg <= 1'b1;
    end else begin
      fresh_reg <= 1'b0;
      if (cmd_valid && (cmd_ready || done || fresh_reg)) cur_reg <= cmd;
    end
  end
  AST_STEP_ONE:
  assert property ($changed(code_shadow) |-> code_shadow
    - $past(code_shadow) inside {6'h01, 6'h3F}) else $error("step size");
  AST_STEP_DIR:
  assert property ($changed(code_shadow) |-> (code_shadow
    > $past(code_shadow)) == cur_reg.up) else $error("step direction");
  AST_DIR_SETUP:
  assert property ($rose(pins.sel_oe) |-> pins.updn_out == (cur_reg.up
    || cur_reg.steps == 6'h00) && $past(pins.updn_out, 20)
    == pins.updn_out) else $error("dir setup");
  AST_UPDN_DRIVEN:
  assert property (pins.updn_oe) else $error("step pin released");
  AST_LOCK_HV:
  assert property ($changed(lock_shadow) |-> cur_reg.high_voltage
    && lock_shadow == cur_reg.flag) else $error("lock change");
  AST_LOCKED_ELEV:
  assert property (lock_shadow && pins.sel_oe
    |-> pins.elevated_select_level) else $error("low select locked");
  AST_END_LEVEL:
  assert property ($fell(pins.sel_oe) |-> $past(pins.updn_out) ==
    (cur_reg.flag || (!cur_reg.high_voltage
    && $past(pins.elevated_select_level)))) else $error("end level");
  AST_IDLE_FREE:
  assert property (cmd_ready || done |-> !pins.sel_oe ##1 !done)
    else $error("select held in idle");
  AST_CODE_HELD:
  assert property (!pins.sel_oe |-> $stable(code_shadow))
    else $error("code moved unselected");
endmodule : updn_host_monitor
`default_nettype wire

// ### sim/updn_pot_model.sv
// behavioural model of the up/down potentiometer device
// assumes the host pins struct; released select reads normal high
`timescale 1ns/100ps
`default_nettype none
module updn_pot_model
  import updn_host_pkg::*;
(
  // host pins
  input wire updn_host_pkg::pins_type pins,
  // device state
  output logic [5:0] wiper, // 3F at A, 00 at B
  output logic [5:0] nv_code,
  output logic locked
);
  logic active;
  logic hv;
  logic up;
  time busy_until;
  wire logic sel_lo = pins.sel_oe && !pins.elevated_select_level
    && !pins.sel_out;
  wire logic sel_hh = pins.sel_oe && pins.elevated_select_level;
  // power-up recall of the saved code
  initial begin
    nv_code = 6'h1F;
    wiper = nv_code;
    locked = 1'b0;
    active = 1'b0;
    busy_until = 0;
  end
  // entry: class and direction latched, ignored while writing
  always @(posedge sel_lo or posedge sel_hh) begin
    if ($time >= busy_until) begin
      active = 1'b1;
      hv = sel_hh;
      up = pins.updn_out;
    end
  end
  // one step per rising edge while selected
  always @(posedge pins.updn_out) begin
    if (active && (hv || !locked)) begin
      if (up && wiper != 6'h3F) wiper = wiper + 6'h01;
      else if (!up && wiper != 6'h00) wiper = wiper - 6'h01;
    end
  end
  // exit: store and lock update, then write time
  always @(negedge sel_lo or negedge sel_hh) begin
    if (active && (hv || (!locked && pins.updn_out))) begin
      nv_code = wiper;
      busy_until = $time + 1000;
    end
    if (active && hv) locked = pins.updn_out;
    active = 1'b0;
  end
endmodule : updn_pot_model
`default_nettype wire

// ### sim/testbench.sv
// self-checking bench for the potentiometer host controller
// assumes the device model and the port monitor alongside
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import updn_host_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  cmd_type cmd = '0;
  logic cmd_ready, done, lock_shadow, locked, exp_lock = 1'b0;
  logic ce = 1'b1;
  logic code_known;
  logic [5:0] code_shadow, wiper, nv_code;
  logic [5:0] exp_code = 6'h1F;
  logic [5:0] exp_nv = 6'h1F;
  pins_type pins;
  int miscompares = 0;
  int tests_run = 0;
  // 50 MHz clock
  always #10 clk = ~clk;
  updn_host #(.WRITE_CYCLES(50)) u_dut (.clk(clk), .resetn(resetn),
    .ce(ce), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .done(done), .lock_shadow(lock_shadow), .code_shadow(code_shadow),
    .code_known(code_known), .pins(pins));
  updn_pot_model u_pot (.pins(pins), .wiper(wiper), .nv_code(nv_code),
    .locked(locked));
  // compare one value
  task automatic check(input string what, input logic [5:0] seen,
    input logic [5:0] want);
    tests_run++;
    if (seen !== want) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  // counts and verdict
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  // one command, with device state predicted beside it
  task automatic run(input logic up, hv, flag, input logic [5:0] steps,
    input int pause = 0);
    int n;
    logic [5:0] held;
    pins_type held_pins;
    cmd = '{up, hv, flag, steps};
    cmd_valid = 1'b1;
    @(posedge clk);
    #2 cmd_valid = 1'b0;
    // optional freeze by the clock enable in mid-command
    if (pause > 0) begin
      repeat (pause) @(posedge clk);
      #2 ce = 1'b0;
      held = code_shadow;
      held_pins = pins;
      repeat (100) @(posedge clk);
      #2 check("frozen code", code_shadow, held);
      check("frozen wiper", wiper, held);
      check("frozen pins", {1'b0, pins}, {1'b0, held_pins});
      ce = 1'b1;
    end
    for (n = 0; n < 2000 && done !== 1'b1; n++) begin
      @(posedge clk);
      #2;
    end
    if (n == 2000) begin
      miscompares++;
      conclude();
    end
    for (n = 0; n < steps; n++) begin
      if (up && exp_code != 6'h3F) exp_code++;
      else if (!up && exp_code != 6'h00) exp_code--;
    end
    if (hv || exp_lock || flag) exp_nv = exp_code;
    if (hv) exp_lock = flag;
    check("wiper", wiper, exp_code);
    check("shadow", code_shadow, exp_code);
    check("stored", nv_code, exp_nv);
    check("lock", {5'h00, locked}, {5'h00, exp_lock});
    check("lk_shadow", {5'h00, lock_shadow}, {5'h00, exp_lock});
  endtask : run
  // reset state
  task automatic t_reset;
    check("reset code", code_shadow, 6'h1F);
    check("reset pot", wiper, 6'h1F);
    check("known", {5'h00, code_known}, 6'h00);
    $display("test reset done");
  endtask : t_reset
  // standard step, step with store, store only
  task automatic t_standard;
    run(1'b1, 1'b0, 1'b0, 6'd3, 52);
    run(1'b0, 1'b0, 1'b1, 6'd2);
    run(1'b1, 1'b0, 1'b1, 6'd0);
    run(1'b0, 1'b0, 1'b1, 6'd0);
    $display("test standard done");
  endtask : t_standard
  // full sweeps into both ends
  task automatic t_saturate;
    run(1'b1, 1'b0, 1'b0, 6'd63);
    run(1'b0, 1'b0, 1'b1, 6'd63);
    $display("test saturate done");
  endtask : t_saturate
  // lock, step while locked, unlock, standard again
  task automatic t_lock;
    run(1'b1, 1'b1, 1'b1, 6'd1);
    run(1'b1, 1'b0, 1'b0, 6'd2);
    run(1'b0, 1'b1, 1'b0, 6'd0);
    run(1'b1, 1'b0, 1'b0, 6'd1);
    $display("test lock done");
  endtask : t_lock
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    #2 resetn = 1'b1;
    t_reset();
    t_standard();
    t_saturate();
    t_lock();
    conclude();
  end
  // hang guard
  initial begin
    #800000;
    miscompares++;
    conclude();
  end
endmodule : testbench
bind updn_host updn_host_monitor u_mon (.clk(clk), .resetn(resetn),
  .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .done(done),
  .lock_shadow(lock_shadow), .code_shadow(code_shadow), .pins(pins));
`default_nettype wire
